// ==== dps_pkg.sv ====
// ****************************************************************
// shared constants and carriers for the dual-port memory block
// ****************************************************************
package dps_pkg;

    // ****************************************************************
    // geometry
    // ****************************************************************
    localparam int ADDR_W  = 6;             // word address width, narrow mode
    localparam int IDX_W   = 5;             // word index width, byte mode
    localparam int DATA_W  = 8;             // data bus width
    localparam int NIB_W   = 4;             // narrow word width
    localparam int LANES   = 2;             // nibble lanes per stored byte
    localparam int WORDS   = 32;            // stored bytes, 256 bits in all
    localparam int ADDR_HI = 5;             // address bit dropped in byte mode
    localparam int SYNC_N  = 3;             // flops on every pin input

    // ****************************************************************
    // constant values
    // ****************************************************************
    localparam logic [LANES-1:0]  LANE_BOTH = 2'h3;   // byte write
    localparam logic [LANES-1:0]  LANE_LO   = 2'h1;   // low nibble write
    localparam logic [LANES-1:0]  LANE_HI   = 2'h2;   // high nibble write
    localparam logic [NIB_W-1:0]  NIB_ZERO  = 4'h0;   // unused upper nibble
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;  // read data after reset

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic              clk;            // write clock pin level
        logic              en;             // write enable
        logic [ADDR_W-1:0] addr;           // write word address
        logic [DATA_W-1:0] data;           // write data
    } dps_wr_s;

    typedef struct packed {
        logic              clk;            // read clock pin level
        logic [ADDR_W-1:0] addr;           // read word address
    } dps_rd_s;

endpackage

// ==== dps_mem.sv ====
`timescale 1ns/1ps
// ****************************************************************
// storage array: 32 bytes, written per nibble lane, registered read
// ****************************************************************
module dps_mem
    import dps_pkg::*;
(
    // clock
    input  wire logic              mclk,
    // write side
    input  wire logic [LANES-1:0]  wr_lane_en,
    input  wire logic [IDX_W-1:0]  wr_idx,
    input  wire logic [DATA_W-1:0] wr_data,
    // read side
    input  wire logic              rd_en,
    input  wire logic [IDX_W-1:0]  rd_idx,
    output logic      [DATA_W-1:0] rd_data_q
);

    // one nibble array per lane, so every lane's storage has a single writer
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [NIB_W-1:0] lane_q [0:WORDS-1];  // no reset: contents undefined at power-up
            logic [NIB_W-1:0] rd_nib_q;            // registered read of this lane

            // write only the lanes enabled this cycle
            always_ff @(posedge mclk) begin
                if (wr_lane_en[g]) begin
                    lane_q[wr_idx] <= wr_data[g*NIB_W +: NIB_W];
                end
            end

            // read returns old contents on a same-cycle write to the same word
            always_ff @(posedge mclk) begin
                if (rd_en) begin
                    rd_nib_q <= lane_q[rd_idx];
                end
            end

            // each lane fills its own slice of the registered read word
            assign rd_data_q[g*NIB_W +: NIB_W] = rd_nib_q;
        end
    endgenerate

endmodule

// ==== dps_sram.sv ====
`timescale 1ns/1ps
// Summary of operation
// - 256 bits, as 32x8 or 64x4
// - independent read and write ports, concurrent
// - six-bit address picks one of 64 nibbles
// - byte mode ignores address bit five
// - each port clock has selectable edge polarity
// - eight-bit write bus, eight-bit read bus
module dps_sram
    import dps_pkg::*;
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              reset,
    // static configuration
    input  wire logic              byte_mode,
    input  wire logic              wclk_active_high,
    input  wire logic              rclk_active_high,
    // write port pins
    input  wire logic              write_clk,
    input  wire logic              write_enable,
    input  wire logic [ADDR_W-1:0] write_word_address,
    input  wire logic [DATA_W-1:0] write_data_bus,
    // read port pins
    input  wire logic              read_clk,
    input  wire logic [ADDR_W-1:0] read_word_address,
    output logic      [DATA_W-1:0] read_data_bus,
    output logic                   read_done
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    dps_wr_s wsync_q [0:SYNC_N-1];          // write pins, three stages
    dps_rd_s rsync_q [0:SYNC_N-1];          // read pins, three stages
    logic    wlvl_q;                        // last accepted write clock level
    logic    rlvl_q;                        // last accepted read clock level
    logic    wr_evt;                        // active write edge seen
    logic    rd_evt;                        // active read edge seen

    // three stages cost latency but keep a metastable first flop away from the edge logic
    // whole bundles move together so address and data line up with the clock edge
    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int i = 0; i < SYNC_N; i++) begin
                wsync_q[i] <= '0;
                rsync_q[i] <= '0;
            end
        end else begin
            wsync_q[0] <= '{clk: write_clk, en: write_enable,
                            addr: write_word_address, data: write_data_bus};
            rsync_q[0] <= '{clk: read_clk, addr: read_word_address};
            for (int i = 1; i < SYNC_N; i++) begin
                wsync_q[i] <= wsync_q[i-1];
                rsync_q[i] <= rsync_q[i-1];
            end
        end
    end

    // accepted clock level follows only once stages two and three agree
    always_ff @(posedge mclk) begin
        if (reset) begin
            wlvl_q <= 1'b0;
            rlvl_q <= 1'b0;
        end else begin
            if (wsync_q[1].clk == wsync_q[2].clk) begin
                wlvl_q <= wsync_q[2].clk;
            end
            if (rsync_q[1].clk == rsync_q[2].clk) begin
                rlvl_q <= rsync_q[2].clk;
            end
        end
    end

    // a pin pulse shorter than one mclk period never settles and is lost
    // active edge: a settled change toward the selected polarity
    always_comb begin
        wr_evt = (wsync_q[1].clk == wsync_q[2].clk) && (wsync_q[2].clk != wlvl_q)
                 && (wsync_q[2].clk == wclk_active_high);
        rd_evt = (rsync_q[1].clk == rsync_q[2].clk) && (rsync_q[2].clk != rlvl_q)
                 && (rsync_q[2].clk == rclk_active_high);
    end

    // ****************************************************************
    // write address and lane decode
    // ****************************************************************
    logic [LANES-1:0]  wr_lane_en;          // nibble lanes written this cycle
    logic [IDX_W-1:0]  wr_idx;              // stored byte index
    logic [DATA_W-1:0] wr_data;             // data steered to its lane

    // shared by both ports: which lanes a six-bit address touches
    function automatic logic [LANES-1:0] lane_of(input logic bm, input logic [ADDR_W-1:0] a);
        lane_of = bm ? LANE_BOTH : (a[ADDR_HI] ? LANE_HI : LANE_LO);
    endfunction

    always_comb begin
        // bit five never reaches the index; in narrow mode it only picks the lane
        wr_idx     = wsync_q[2].addr[IDX_W-1:0];
        wr_lane_en = (wr_evt && wsync_q[2].en) ?
                     lane_of(byte_mode, wsync_q[2].addr) : '0;
        // narrow data always enters on the low nibble, copied to both lanes
        wr_data    = byte_mode ? wsync_q[2].data :
                     {wsync_q[2].data[NIB_W-1:0], wsync_q[2].data[NIB_W-1:0]};
    end

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [DATA_W-1:0] mem_rd;              // registered array output

    // reset leaves the array and mem_rd alone; the read output and done registers clear
    // separate read and write decode lets both ports act in one cycle
    dps_mem u_mem (
        .mclk       (mclk),
        .wr_lane_en (wr_lane_en),
        .wr_idx     (wr_idx),
        .wr_data    (wr_data),
        .rd_en      (rd_evt),
        .rd_idx     (rsync_q[2].addr[IDX_W-1:0]),
        .rd_data_q  (mem_rd)
    );

    // ****************************************************************
    // read data path
    // ****************************************************************
    logic              rd_pend_q;           // array read in flight
    logic [LANES-1:0]  rd_lane_q;           // lane chosen at the read edge
    logic [DATA_W-1:0] rd_data_q;           // read data output register
    logic              rd_done_q;           // one-cycle completion pulse

    // lane and mode are caught with the edge so a later change cannot tear the word
    always_ff @(posedge mclk) begin
        if (reset) begin
            rd_pend_q <= 1'b0;
            rd_lane_q <= '0;
        end else begin
            rd_pend_q <= rd_evt;
            if (rd_evt) begin
                rd_lane_q <= lane_of(byte_mode, rsync_q[2].addr);
            end
        end
    end

    // output register holds until the read started by the next active read edge completes
    always_ff @(posedge mclk) begin
        if (reset) begin
            rd_data_q <= DATA_ZERO;
            rd_done_q <= 1'b0;
        end else begin
            rd_done_q <= rd_pend_q;
            if (rd_pend_q) begin
                // narrow reads zero-extend the nibble, byte reads pass all eight bits
                unique case (rd_lane_q)
                    LANE_LO: begin
                        rd_data_q <= {NIB_ZERO, mem_rd[NIB_W-1:0]};
                    end
                    LANE_HI: begin
                        rd_data_q <= {NIB_ZERO, mem_rd[DATA_W-1:NIB_W]};
                    end
                    default: begin
                        rd_data_q <= mem_rd;
                    end
                endcase
            end
        end
    end

    // outputs straight from flops, nothing after the register
    assign read_data_bus = rd_data_q;
    assign read_done     = rd_done_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // checks sleep through reset, where the output register is cleared on purpose

    // read port: timing, hold and nibble steering
    a_rd_latency: assert property (rd_evt |-> ##2 rd_done_q)
        else $error("read data not updated two cycles after read edge");
    a_rd_hold: assert property (!rd_done_q |-> $stable(read_data_bus))
        else $error("read data changed without a read");
    a_nib_upper: assert property (rd_done_q && $past(rd_lane_q) != LANE_BOTH
        |-> read_data_bus[DATA_W-1:NIB_W] == NIB_ZERO)
        else $error("narrow read left upper nibble set");
    a_rd_byte: assert property (rd_done_q && $past(rd_lane_q) == LANE_BOTH
        |-> read_data_bus == $past(mem_rd))
        else $error("byte read did not pass the whole stored word");
    a_rd_lane: assert property (rd_evt && byte_mode |=> rd_lane_q == LANE_BOTH)
        else $error("byte read did not take both nibbles");

    // write port: lane choice, gating and data steering
    a_byte_lanes: assert property (byte_mode && wr_evt && wsync_q[2].en
        |-> wr_lane_en == LANE_BOTH && wr_idx == wsync_q[2].addr[IDX_W-1:0])
        else $error("byte write did not ignore address bit five");
    a_nib_lane: assert property (!byte_mode && wr_evt && wsync_q[2].en
        |-> wr_lane_en == (wsync_q[2].addr[ADDR_HI] ? LANE_HI : LANE_LO))
        else $error("narrow write hit the wrong nibble");
    a_wr_gate: assert property (wr_lane_en != '0 |-> wr_evt && wsync_q[2].en)
        else $error("write without enabled active edge");
    a_wr_data: assert property (wr_lane_en == LANE_LO
        |-> wr_data[NIB_W-1:0] == wsync_q[2].data[NIB_W-1:0])
        else $error("narrow write data not on low nibble");
    a_wr_hi_data: assert property (wr_lane_en == LANE_HI
        |-> wr_data[DATA_W-1:NIB_W] == wsync_q[2].data[NIB_W-1:0])
        else $error("narrow write data not steered to the high nibble");

    // clock pins: only the selected polarity makes an edge
    a_wclk_pol: assert property (wr_evt |-> $past(wsync_q[1].clk) == wclk_active_high
        && wlvl_q != wclk_active_high)
        else $error("write edge taken on the wrong polarity");
    a_rclk_pol: assert property (rd_evt |=> rlvl_q == rclk_active_high)
        else $error("read edge taken on the wrong polarity");

    // main scenarios: byte and narrow traffic, both polarities, both ports at once
    c_byte_read:  cover property (byte_mode && rd_evt ##2 rd_done_q);
    c_nib_read:   cover property (!byte_mode && rd_evt ##2 rd_done_q);
    c_nib_write:  cover property (!byte_mode && wr_lane_en == LANE_HI);
    c_fall_write: cover property (!wclk_active_high && wr_lane_en != '0);
    c_concurrent: cover property (rd_evt && wr_lane_en != '0);

endmodule

// ==== dps_user_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// user logic model: drives both port pins of one memory block
// ****************************************************************
module dps_user_model
    import dps_pkg::*;
(
    // clock
    input  wire logic              mclk,
    // polarity selects, to know the idle level
    input  wire logic              wclk_active_high,
    input  wire logic              rclk_active_high,
    // write port pins
    output logic                   write_clk,
    output logic                   write_enable,
    output logic      [ADDR_W-1:0] write_word_address,
    output logic      [DATA_W-1:0] write_data_bus,
    // read port pins
    output logic                   read_clk,
    output logic      [ADDR_W-1:0] read_word_address,
    input  wire logic [DATA_W-1:0] read_data_bus,
    input  wire logic              read_done
);
    int hold_n = 4;  // cycles per pin phase; raise it for a slow partner

    // pins start idle for rising polarity
    initial begin
        write_clk          = 1'b0;
        write_enable       = 1'b0;
        write_word_address = 6'h00;
        write_data_bus     = 8'h00;
        read_clk           = 1'b0;
        read_word_address  = 6'h00;
    end

    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // one write: set-up, active edge, back to idle; pins held past each edge
    task automatic do_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                            input logic en);
        write_clk          <= ~wclk_active_high;
        write_enable       <= en;
        write_word_address <= a;
        write_data_bus     <= d;
        wait_n(hold_n);
        write_clk <= wclk_active_high;
        wait_n(hold_n);
        write_clk <= ~wclk_active_high;
        wait_n(hold_n);
        // hold time over: show inverted values so stale ones cannot pass as held
        write_word_address <= ~a;
        write_data_bus     <= ~d;
        write_enable       <= 1'b0;
        wait_n(1);
    endtask

    // one read: active edge, then take the data in the done cycle
    task automatic do_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q,
                           output logic ok);
        ok = 1'b0;
        q  = DATA_ZERO;
        read_clk          <= ~rclk_active_high;
        read_word_address <= a;
        wait_n(hold_n);
        read_clk <= rclk_active_high;
        // done is a one-cycle pulse: look at it mid-cycle where it is settled
        for (int i = 0; i < 12 && !ok; i++) begin
            @(negedge mclk);
            ok = (read_done === 1'b1);
            q  = read_data_bus;
        end
        wait_n(hold_n);
        read_clk <= ~rclk_active_high;
        wait_n(hold_n);
        read_word_address <= ~a;
        wait_n(1);
    endtask
endmodule

// ==== dps_sram_tb_top.sv ====
`timescale 1ns/1ps
// ****************************************************************
// testbench: memory block driven by the user logic model
// ****************************************************************
module dps_sram_tb_top
    import dps_pkg::*;
;
    logic              mclk = 1'b0;        // 40 MHz system clock
    logic              reset;              // synchronous, active high
    logic              byte_mode;          // 32x8 when high
    logic              wclk_active_high;   // write edge polarity
    logic              rclk_active_high;   // read edge polarity
    logic              write_clk, write_enable, read_clk, read_done;
    logic [ADDR_W-1:0] write_word_address, read_word_address;
    logic [DATA_W-1:0] write_data_bus, read_data_bus, q;
    logic              ok;                 // read completed in time
    int                err_count = 0;      // mismatches
    int                checked   = 0;      // comparisons made

    always #12.5 mclk = ~mclk;

    dps_sram uut (.mclk(mclk), .reset(reset), .byte_mode(byte_mode),
        .wclk_active_high(wclk_active_high), .rclk_active_high(rclk_active_high),
        .write_clk(write_clk), .write_enable(write_enable),
        .write_word_address(write_word_address), .write_data_bus(write_data_bus),
        .read_clk(read_clk), .read_word_address(read_word_address),
        .read_data_bus(read_data_bus), .read_done(read_done));

    dps_user_model model (.mclk(mclk), .wclk_active_high(wclk_active_high),
        .rclk_active_high(rclk_active_high), .write_clk(write_clk),
        .write_enable(write_enable), .write_word_address(write_word_address),
        .write_data_bus(write_data_bus), .read_clk(read_clk),
        .read_word_address(read_word_address), .read_data_bus(read_data_bus),
        .read_done(read_done));

    // ****************************************************************
    // checking and closing
    // ****************************************************************
    task automatic cmp8(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("errors=%0d checks=%0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // read one word; a missing done pulse counts as a mismatch too
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        model.do_read(a, q, ok);
        cmp8({7'h00, ok}, 8'h01);
        cmp8(q, exp);
    endtask

    // fill pattern: distinct for every byte, low three bits fixed at 3'b011
    function automatic logic [DATA_W-1:0] fd(input int a);
        return {a[4:0], 3'h0} ^ 8'hc3;
    endfunction

    // reset with new polarities; outputs clear, array keeps its contents
    task automatic t_reset(input logic wp, input logic rp);
        reset            <= 1'b1;
        wclk_active_high <= wp;
        rclk_active_high <= rp;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        @(negedge mclk);
        cmp8(read_data_bus, DATA_ZERO);
        cmp8({7'h00, read_done}, 8'h00);
        @(posedge mclk);
    endtask

    // every byte written then read back in byte mode
    task automatic t_fill();
        for (int a = 0; a < WORDS; a++) model.do_write(6'(a), fd(a), 1'b1);
        for (int a = 0; a < WORDS; a++) rd_chk(6'(a), fd(a));
    endtask

    // byte mode drops address bit five on both ports
    task automatic t_ignore_hi();
        model.do_write(6'h27, 8'h3c, 1'b1);
        rd_chk(6'h07, 8'h3c);
        rd_chk(6'h27, 8'h3c);
    endtask

    // narrow mode: nibbles by six-bit address, disabled write refused
    task automatic t_narrow();
        byte_mode <= 1'b0;
        model.do_write(6'h09, 8'hf6, 1'b1);
        model.do_write(6'h29, 8'h0b, 1'b1);
        model.do_write(6'h09, 8'h01, 1'b0);
        rd_chk(6'h09, 8'h06);
        rd_chk(6'h29, 8'h0b);
        byte_mode <= 1'b1;
        // the block built this byte from two narrow words, steering each by bit five
        rd_chk(6'h09, 8'hb6);
    endtask

    // read and write edges in the same cycle, same word and another word
    task automatic t_concurrent();
        fork
            model.do_write(6'h10, 8'h99, 1'b1);
            rd_chk(6'h10, fd(16));
        join
        rd_chk(6'h10, 8'h99);
        fork
            model.do_write(6'h11, 8'h44, 1'b1);
            rd_chk(6'h12, fd(18));
        join
        rd_chk(6'h11, 8'h44);
    endtask

    // falling write edge, rising read edge, slow partner
    task automatic t_polarity();
        t_reset(1'b0, 1'b1);
        rd_chk(6'h10, 8'h99);
        model.hold_n = 8;
        model.do_write(6'h01, 8'ha7, 1'b1);
        rd_chk(6'h01, 8'ha7);
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        reset            = 1'b1;
        byte_mode        = 1'b1;
        wclk_active_high = 1'b1;
        rclk_active_high = 1'b1;
        @(posedge mclk);
        t_reset(1'b1, 1'b1);
        t_fill();
        t_ignore_hi();
        t_narrow();
        t_concurrent();
        t_polarity();
        end_sim();
    end

    // about 1300 cycles expected; far beyond that means a hang
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        end_sim();
    end
endmodule
